// ===== design/phase_realign_enable_zcd_consts.vh
/*
 * constants for the second-stage phase_realign_enable supervisor and zcd delay block:
 * register offsets, field positions, reset values, timing figures.
 * assumes inclusion by bare name from design and test files.
 */
`ifndef PHASE_REALIGN_ENABLE_ZCD_CONSTS_VH
`define PHASE_REALIGN_ENABLE_ZCD_CONSTS_VH

// register indices as printed; byte address is four times the index
`define IDX_PHASE_PHASE_REALIGN_ENABLE 8'h2f
`define IDX_ZCD_FAULT 8'h30
`define IDX_PHASE_REALIGN_ENABLE_CTRL 8'h31
`define IDX_IRQ_STATUS 8'h32
`define IDX_IRQ_MASK 8'h33
`define IDX_SUPER_STATE 8'h34

// phase_phase_realign_enable_settings fields
`define HYST_HI 7
`define HYST_LO 4
`define THR_HI 3
`define THR_LO 0

// zcd_delay_and_fault_settings fields
`define RISE_HI 7
`define RISE_LO 5
`define VALLEY_HI 4
`define VALLEY_LO 2
`define SCP_DIS_BIT 1
`define VOLTAGE_DIFFERENCE_FAULT_DISABLE_DIS_BIT 0

// phase_realign_enable control register
`define REALIGN_EN_BIT 6

// irq bits
`define IRQ_PHASE_REALIGN_ENABLE 0
`define IRQ_SC_FAULT 1
`define IRQ_VOLTAGE_DIFFERENCE_FAULT_DISABLE_FAULT 2
`define IRQ_W 3

// reset values
`define RST_PHASE_PHASE_REALIGN_ENABLE 8'h00
`define RST_ZCD_FAULT 8'h00
`define RST_PHASE_REALIGN_ENABLE_CTRL 8'h00
`define RST_IRQ_MASK 3'h0

// delay step in ns, clock period in ns
`define ZCD_STEP_NS 50
`define CLK_PERIOD_NS 10

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== design/zcd_edge_delay.v
/*
 * fixed rising-edge delay for a synchronised zcd comparator level.
 * assumes the input is already in the aclk domain; a rise is reported
 * setting*step cycles later as a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "phase_realign_enable_zcd_consts.vh"

module zcd_edge_delay #(
  parameter STEP_CYCLES = 5,
  parameter CNT_W = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire level,
  input wire [2:0] setting,
  output reg event_pulse
);
  reg level_d;
  reg busy;
  reg [CNT_W-1:0] count;
  wire [CNT_W-1:0] target;

  // total wait in cycles; zero setting reports on the edge itself
  assign target = setting * STEP_CYCLES[CNT_W-1:0];

  // a new rise during an active wait restarts it; the earlier edge then gives no delayed event
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_d <= 1'b0;
      busy <= 1'b0;
      count <= {CNT_W{1'b0}};
      event_pulse <= 1'b0;
    end
    else
    begin
      level_d <= level;
      event_pulse <= 1'b0;
      if (level && !level_d)
      begin
        if (target == {CNT_W{1'b0}})
          event_pulse <= 1'b1;
        else
        begin
          busy <= 1'b1;
          count <= {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      else if (busy)
      begin
        if (count >= target)
        begin
          busy <= 1'b0;
          event_pulse <= 1'b1;
        end
        else
          count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // zcd_edge_delay

// ===== design/phase_realign_enable_zcd_config.v
/*
 * second-stage phase phase_realign_enable supervisor with zcd compensation delays and
 * fault gating, registers reached over axi4-lite.
 * assumes analog comparators, period ticks and fault flags arrive as
 * asynchronous levels or pulses and pass a two-flop synchroniser here.
 */
// How it works
// R1: hysteresis field holds 0..15 channel 1 periods between resyncs.
// R2: misid counter adds one per bad period, subtracts two per good one.
// R3: phase_realign_enable when counter exceeds threshold and hysteresis periods have elapsed.
// R4: software sets these fields only for indirect sync circuits, with enable set; the block takes writes to them with enable clear too.
// R5: channel 2 zcd rising edge recognised after setting times 50 ns.
// R6: channel 2 valley zcd event delayed by setting times 50 ns.
// R7: short-circuit protection active when its bit is 0, off when 1.
// R8: voltage-difference fault acted on when its bit is 0, ignored when 1.
// R9: supervisor runs only while the realign enable bit is 1.
// R10: counter floors at zero, clears on phase_realign_enable; hysteresis count restarts.
`timescale 1ns/1ps
`include "phase_realign_enable_zcd_consts.vh"

module phase_realign_enable_zcd_config #(
  parameter MISID_W = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ch1_period_tick,
  input wire ch2_period_tick,
  input wire output_id_proper,
  input wire ch2_valley_detect_delay_rise,
  input wire zero_current_detect,
  input wire ch2_cycle,
  input wire short_circuit_detect,
  input wire voltage_difference_detect,
  output reg phase_realign,
  output reg ch2_rise_event,
  output reg ch2_valley_event,
  output reg short_circuit_fault,
  output reg voltage_difference_fault,
  output reg irq
);
  localparam integer STEP_CYCLES = (`ZCD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_RUN = 2'b10;

  // byte address to printed index match
  function hit;
    input [31:0] addr;
    input [7:0] idx;
    begin
      hit = (addr[1:0] == 2'h0) && (addr[31:2] == {22'h0, idx});
    end
  endfunction

  reg [7:0] phase_phase_realign_enable_settings;
  reg [7:0] zcd_delay_and_fault_settings;
  reg [7:0] phase_realign_enable_ctrl;
  reg [`IRQ_W-1:0] irq_status;
  reg [`IRQ_W-1:0] irq_mask;
  reg [1:0] state;
  reg [MISID_W-1:0] misid_count;
  reg [3:0] hyst_count;
  reg [MISID_W-1:0] next_misid;
  reg [4:0] sync1;
  reg [4:0] sync2;
  reg [4:0] sync2_d;
  reg [2:0] lvl1;
  reg [2:0] lvl2;
  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire rise_pulse;
  wire valley_pulse;
  wire [3:0] phase_realign_enable_hysteresis_periods;
  wire [3:0] misid_threshold;
  wire phase_realign_enable;
  wire ch1_tick;
  wire ch2_tick;
  wire phase_realign_enable_now;
  wire wr_go;
  wire rd_go;
  wire [`IRQ_W-1:0] events;

  assign phase_realign_enable_hysteresis_periods = phase_phase_realign_enable_settings[`HYST_HI:`HYST_LO]; // [R1]
  assign misid_threshold = phase_phase_realign_enable_settings[`THR_HI:`THR_LO];
  assign phase_realign_enable = phase_realign_enable_ctrl[`REALIGN_EN_BIT];

  // two flops on every outside input; edges taken from the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync2_d <= 5'h00;
      lvl1 <= 3'h0;
      lvl2 <= 3'h0;
    end
    else
    begin
      sync1 <= {voltage_difference_detect, short_circuit_detect, output_id_proper,
                ch2_period_tick, ch1_period_tick};
      sync2 <= sync1;
      sync2_d <= sync2;
      lvl1 <= {ch2_cycle, zero_current_detect, ch2_valley_detect_delay_rise};
      lvl2 <= lvl1;
    end
  end

  // period ticks are pulses from the stage; one event per rising edge
  assign ch1_tick = sync2[0] && !sync2_d[0];
  assign ch2_tick = sync2[1] && !sync2_d[1];

  // hysteresis satisfied and counter strictly above threshold; a good period may fire too
  assign phase_realign_enable_now = (state == S_RUN) && ch2_tick &&
    (next_misid > {1'b0, misid_threshold}) && (hyst_count >= phase_realign_enable_hysteresis_periods); // [R3]

  // misid counter step for this second-stage period
  always @*
  begin
    next_misid = misid_count;
    if (ch2_tick)
    begin
      if (sync2[2])
        next_misid = (misid_count > {{(MISID_W-2){1'b0}}, 2'h2}) ?
          misid_count - {{(MISID_W-2){1'b0}}, 2'h2} : {MISID_W{1'b0}}; // [R2] [R10]
      else if (misid_count != {MISID_W{1'b1}})
        next_misid = misid_count + {{(MISID_W-1){1'b0}}, 1'b1}; // [R2]
    end
  end

  // supervisor fsm; disabled state parks everything at zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= S_IDLE;
      misid_count <= {MISID_W{1'b0}};
      hyst_count <= 4'h0;
      phase_realign <= 1'b0;
    end
    else
    begin
      phase_realign <= 1'b0;
      case (state)
        S_IDLE:
        begin
          misid_count <= {MISID_W{1'b0}};
          hyst_count <= 4'h0;
          if (phase_realign_enable) // [R9]
            state <= S_RUN;
        end
        S_RUN:
        begin
          if (!phase_realign_enable) // [R9]
            state <= S_IDLE;
          else if (phase_realign_enable_now)
          begin
            phase_realign <= 1'b1;
            misid_count <= {MISID_W{1'b0}}; // [R10]
            hyst_count <= 4'h0; // [R10]
          end
          else
          begin
            misid_count <= next_misid;
            // saturate so a long quiet stretch still counts as elapsed
            if (ch1_tick && hyst_count != 4'hf)
              hyst_count <= hyst_count + 4'h1; // [R1]
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // channel 2 rising-edge compensation
  zcd_edge_delay #(
    .STEP_CYCLES(STEP_CYCLES),
    .CNT_W(6)
  ) u_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(lvl2[0]),
    .setting(zcd_delay_and_fault_settings[`RISE_HI:`RISE_LO]), // [R5]
    .event_pulse(rise_pulse)
  );

  // valley compensation; comparator only counted in channel 2 cycles
  zcd_edge_delay #(
    .STEP_CYCLES(STEP_CYCLES),
    .CNT_W(6)
  ) u_valley (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(lvl2[1] && lvl2[2]), // [R6]
    .setting(zcd_delay_and_fault_settings[`VALLEY_HI:`VALLEY_LO]), // [R6]
    .event_pulse(valley_pulse)
  );

  // fault gating and registered delayed events
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch2_rise_event <= 1'b0;
      ch2_valley_event <= 1'b0;
      short_circuit_fault <= 1'b0;
      voltage_difference_fault <= 1'b0;
    end
    else
    begin
      ch2_rise_event <= rise_pulse; // [R5]
      ch2_valley_event <= valley_pulse; // [R6]
      short_circuit_fault <= sync2[3] && !zcd_delay_and_fault_settings[`SCP_DIS_BIT]; // [R7]
      voltage_difference_fault <= sync2[4] && !zcd_delay_and_fault_settings[`VOLTAGE_DIFFERENCE_FAULT_DISABLE_DIS_BIT]; // [R8]
    end
  end

  assign events = {voltage_difference_fault, short_circuit_fault, phase_realign};
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // axi write: address and data taken in either order, one at a time
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      phase_phase_realign_enable_settings <= `RST_PHASE_PHASE_REALIGN_ENABLE;
      zcd_delay_and_fault_settings <= `RST_ZCD_FAULT;
      phase_realign_enable_ctrl <= `RST_PHASE_REALIGN_ENABLE_CTRL;
      irq_mask <= `RST_IRQ_MASK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        // only byte lane 0 carries data; other lanes ignored
        if (hit(aw_addr, `IDX_PHASE_PHASE_REALIGN_ENABLE))
        begin
          if (w_strb[0])
            phase_phase_realign_enable_settings <= w_data[7:0]; // [R4]
        end
        else if (hit(aw_addr, `IDX_ZCD_FAULT))
        begin
          if (w_strb[0])
            zcd_delay_and_fault_settings <= w_data[7:0];
        end
        else if (hit(aw_addr, `IDX_PHASE_REALIGN_ENABLE_CTRL))
        begin
          if (w_strb[0])
            phase_realign_enable_ctrl <= w_data[7:0] & (8'h01 << `REALIGN_EN_BIT);
        end
        else if (hit(aw_addr, `IDX_IRQ_MASK))
        begin
          if (w_strb[0])
            irq_mask <= w_data[`IRQ_W-1:0];
        end
        else if (!hit(aw_addr, `IDX_IRQ_STATUS) && !hit(aw_addr, `IDX_SUPER_STATE))
          s_axi_bresp <= `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read; status clears on read but a same-cycle event still sets
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
      irq_status <= {`IRQ_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= irq_status | events;
      if (rd_go)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (hit(s_axi_araddr, `IDX_PHASE_PHASE_REALIGN_ENABLE))
          s_axi_rdata <= {24'h0, phase_phase_realign_enable_settings};
        else if (hit(s_axi_araddr, `IDX_ZCD_FAULT))
          s_axi_rdata <= {24'h0, zcd_delay_and_fault_settings};
        else if (hit(s_axi_araddr, `IDX_PHASE_REALIGN_ENABLE_CTRL))
          s_axi_rdata <= {24'h0, phase_realign_enable_ctrl};
        else if (hit(s_axi_araddr, `IDX_IRQ_STATUS))
        begin
          s_axi_rdata <= {29'h0, irq_status};
          irq_status <= events;
        end
        else if (hit(s_axi_araddr, `IDX_IRQ_MASK))
          s_axi_rdata <= {29'h0, irq_mask};
        else if (hit(s_axi_araddr, `IDX_SUPER_STATE))
          s_axi_rdata <= {16'h0, 3'h0, misid_count, hyst_count, 3'h0, state == S_RUN};
        else
          s_axi_rresp <= `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      irq <= |((irq_status | events) & irq_mask);
    end
  end
endmodule // phase_realign_enable_zcd_config

// ===== test/phase_realign_enable_zcd_chk.sv
/* port-level assertions for the phase_realign_enable and zcd delay block.
   assumes a bind onto phase_realign_enable_zcd_config; one clock domain. */
`timescale 1ns/1ps
module phase_realign_enable_zcd_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire ch2_period_tick,
  input wire ch2_valley_detect_delay_rise,
  input wire zero_current_detect,
  input wire short_circuit_detect,
  input wire voltage_difference_detect,
  input wire phase_realign,
  input wire ch2_rise_event,
  input wire ch2_valley_event,
  input wire short_circuit_fault,
  input wire voltage_difference_fault
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [5:0] per_age;
  logic [5:0] rise_age;
  logic [5:0] zcd_age;

  // cycles since each cause rose; saturate so stale edges never count
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      per_age <= 6'h3f;
      rise_age <= 6'h3f;
      zcd_age <= 6'h3f;
    end
    else
    begin
      per_age <= $rose(ch2_period_tick) ? 6'h00 : (per_age == 6'h3f ? per_age : per_age + 6'h01);
      rise_age <= $rose(ch2_valley_detect_delay_rise) ? 6'h00 : (rise_age == 6'h3f ? rise_age : rise_age + 6'h01);
      zcd_age <= $rose(zero_current_detect) ? 6'h00 : (zcd_age == 6'h3f ? zcd_age : zcd_age + 6'h01);
    end
  end

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  realign_pulse_a: assert property (phase_realign |=> !phase_realign)
    else $error("realign longer than one cycle");
  realign_cause_a: assert property (phase_realign |-> per_age <= 6'd8)
    else $error("realign without a period edge");
  rise_cause_a: assert property (ch2_rise_event |-> rise_age <= 6'd48)
    else $error("rise event without comparator rise");
  valley_cause_a: assert property (ch2_valley_event |-> zcd_age <= 6'd48)
    else $error("valley event without zcd rise");
  sc_quiet_a: assert property (!short_circuit_detect [*5] |=> !short_circuit_fault)
    else $error("short fault without cause");
  vd_quiet_a: assert property (!voltage_difference_detect [*5] |=> !voltage_difference_fault)
    else $error("voltage_difference_fault_disable fault without cause");
endmodule // phase_realign_enable_zcd_chk

// ===== test/zcd_far_side.sv
/* far-side model: period ticks, comparators, fault lines.
   assumes the bench calls its tasks; all lines are async levels. */
`timescale 1ns/1ps
module zcd_far_side (
  input wire aclk,
  output logic ch1_period_tick,
  output logic ch2_period_tick,
  output logic output_id_proper,
  output logic ch2_valley_detect_delay_rise,
  output logic zero_current_detect,
  output logic ch2_cycle,
  output logic short_circuit_detect,
  output logic voltage_difference_detect
);
  // all lines quiet until commanded
  initial
  begin
    {ch1_period_tick, ch2_period_tick, output_id_proper, ch2_valley_detect_delay_rise, zero_current_detect, ch2_cycle,
      short_circuit_detect, voltage_difference_detect} = 8'h00;
  end

  // one switching period; tick held long enough to pass the synchroniser
  task period(input logic ch2, input logic good);
    begin
      @(posedge aclk);
      output_id_proper <= good;
      if (ch2) ch2_period_tick <= 1'b1;
      else ch1_period_tick <= 1'b1;
      repeat (4) @(posedge aclk);
      ch1_period_tick <= 1'b0;
      ch2_period_tick <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask

  // 0 rise comparator, 1 aux zcd, 2 ch2 cycle, 3 short, 4 voltage_difference_fault_disable
  task level(input int k, input logic v);
    begin
      @(posedge aclk);
      case (k)
        0: ch2_valley_detect_delay_rise <= v;
        1: zero_current_detect <= v;
        2: ch2_cycle <= v;
        3: short_circuit_detect <= v;
        default: voltage_difference_detect <= v;
      endcase
    end
  endtask
endmodule // zcd_far_side

// ===== test/phase_realign_enable_zcd_config_test.sv
/* self-checking bench for phase_realign_enable_zcd_config over axi4-lite.
   assumes zcd_far_side drives the analog side and the checker is bound. */
`timescale 1ns/1ps
`include "phase_realign_enable_zcd_consts.vh"
module phase_realign_enable_zcd_config_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ch1_period_tick, ch2_period_tick, output_id_proper, ch2_valley_detect_delay_rise, zero_current_detect, ch2_cycle;
  logic short_circuit_detect, voltage_difference_detect, phase_realign, ch2_rise_event, ch2_valley_event;
  logic short_circuit_fault, voltage_difference_fault, irq;
  localparam logic [31:0] a_set = 4 * `IDX_PHASE_PHASE_REALIGN_ENABLE;
  localparam logic [31:0] a_zcd = 4 * `IDX_ZCD_FAULT;
  localparam logic [31:0] a_ctl = 4 * `IDX_PHASE_REALIGN_ENABLE_CTRL;
  localparam logic [31:0] a_sts = 4 * `IDX_IRQ_STATUS;
  localparam logic [31:0] a_msk = 4 * `IDX_IRQ_MASK;
  int err_count = 0, check_count = 0, realign_n = 0, valley_n = 0;
  int i, j, k, s, n, dr, dv, d0, v0;
  // 0 ch1 tick, 1 good ch2 period, 2 bad ch2 period
  int ops[24] = '{0, 0, 1, 2, 2, 1, 2, 2, 2, 2, 2, 2, 0, 2, 0, 2, 2, 2, 2, 2, 2, 0, 0, 1};
  int exp_n[24] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 3};

  phase_realign_enable_zcd_config DUT (.*);
  zcd_far_side far (.*);

  always #5 aclk = ~aclk;

  // pulse counters kept apart from the checks so no pulse slips by
  always @(posedge aclk)
  begin
    if (phase_realign === 1'b1) realign_n++;
    if (ch2_valley_event === 1'b1) valley_n++;
  end

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task chk(input logic ok, input string m);
    begin
      check_count++;
      if (ok !== 1'b1)
      begin
        err_count++;
        $display("mismatch at %0t: %s", $time, m);
      end
    end
  endtask

  // a wait that used its whole bound ends the run
  task tmo(input int c);
    begin
      if (c >= 99)
      begin
        chk(1'b0, "wait ran out");
        wrap_up;
      end
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
    int c;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (c = 0; c < 99; c++)
      begin
        @(posedge aclk);
        if ((s_axi_awvalid & s_axi_awready) === 1'b1) s_axi_awvalid <= 1'b0;
        if ((s_axi_wvalid & s_axi_wready) === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      tmo(c);
      chk(s_axi_bresp === r, "write response");
    end
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    int c;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (c = 0; c < 99; c++)
      begin
        @(posedge aclk);
        if ((s_axi_arvalid & s_axi_arready) === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      tmo(c);
      chk(s_axi_rdata === e && s_axi_rresp === r, "read data");
    end
  endtask

  // cycles from comparator rise to the delayed event
  task zmeas(input int z, output int dly);
    begin
      far.level(z, 1'b1);
      for (dly = 0; dly < 99; dly++)
      begin
        @(posedge aclk);
        if ((z == 0 ? ch2_rise_event : ch2_valley_event) === 1'b1) break;
      end
      tmo(dly);
      far.level(z, 1'b0);
      repeat (8) @(posedge aclk);
    end
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(a_set, 32'h0, `RESP_OKAY);
    rchk(a_zcd, 32'h0, `RESP_OKAY);
    rchk(a_ctl, 32'h0, `RESP_OKAY);
    rchk(a_msk, 32'h0, `RESP_OKAY);
    rchk(32'h100, 32'h0, `RESP_SLVERR);
    wr(32'h100, 32'h5a, `RESP_SLVERR);
    wr(a_set, 32'h122, `RESP_OKAY);
    rchk(a_set, 32'h22, `RESP_OKAY);
    $display("end of register test");
    for (i = 0; i < 4; i++) far.period(1'b1, 1'b0);
    chk(realign_n == 0, "realign while disabled");
    wr(a_ctl, 32'h40, `RESP_OKAY);
    for (i = 0; i < 24; i++)
    begin
      far.period(ops[i] != 0, ops[i] == 1);
      chk(realign_n == exp_n[i], "realign count");
    end
    rchk(4 * `IDX_SUPER_STATE, 32'h1, `RESP_OKAY);
    $display("end of phase_realign_enable test");
    far.level(2, 1'b1);
    for (s = 0; s < 8; s++)
    begin
      wr(a_zcd, (s << 5) | (s << 2), `RESP_OKAY);
      zmeas(0, dr);
      zmeas(1, dv);
      if (s == 0) d0 = dr;
      if (s == 0) v0 = dv;
      chk(dr == d0 + 5 * s, "rise delay");
      chk(dv == v0 + 5 * s, "valley delay");
    end
    far.level(2, 1'b0);
    n = valley_n;
    far.level(1, 1'b1);
    repeat (60) @(posedge aclk);
    far.level(1, 1'b0);
    chk(valley_n == n, "valley outside ch2 cycle");
    $display("end of delay test");
    wr(a_sts, 32'h7, `RESP_OKAY);
    rchk(a_sts, 32'h1, `RESP_OKAY);
    chk(irq === 1'b0, "irq while masked");
    wr(a_msk, 32'h7, `RESP_OKAY);
    for (i = 0; i < 4; i++)
    begin
      k = 3 + i / 2;
      j = i % 2;
      wr(a_zcd, j << (4 - k), `RESP_OKAY);
      far.level(k, 1'b1);
      repeat (6) @(posedge aclk);
      chk((k == 3 ? short_circuit_fault : voltage_difference_fault) === !j, "fault output");
      chk(irq === !j, "irq level");
      far.level(k, 1'b0);
      repeat (6) @(posedge aclk);
      rchk(a_sts, j ? 0 : 1 << (k - 2), `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq === 1'b0, "irq after clear");
    end
    wr(a_msk, 32'h0, `RESP_OKAY);
    far.level(3, 1'b1);
    repeat (6) @(posedge aclk);
    chk(irq === 1'b0, "masked irq");
    far.level(3, 1'b0);
    repeat (6) @(posedge aclk);
    rchk(a_sts, 32'h2, `RESP_OKAY);
    $display("end of fault test");
    wrap_up;
  end
endmodule // phase_realign_enable_zcd_config_test

bind phase_realign_enable_zcd_config phase_realign_enable_zcd_chk chk (.*);
